// ==== design/shs_defs.vh ====
// Purpose: constants for the standby halt/stop controller
// Assumes: included by bare name from design files
// Notes: offsets, field positions, reset values and wait codes
`ifndef SHS_DEFS_VH
`define SHS_DEFS_VH
`define SHS_SETTLE_ADDR 16'hfffa
`define SHS_SETTLE_RESET 8'h04
`define SHS_SEL_MSB 2
`define SHS_SEL_LSB 0
`define SHS_SEL_W12 3'h0
`define SHS_SEL_W14 3'h1
`define SHS_SEL_W15 3'h2
`define SHS_SEL_W16 3'h3
`define SHS_SEL_W17 3'h4
`define SHS_EXP_W12 5'h0c
`define SHS_EXP_W14 5'h0e
`define SHS_EXP_W15 5'h0f
`define SHS_EXP_W16 5'h10
`define SHS_EXP_W17 5'h11
`define SHS_WAKE_VEC 4'h8
`define SHS_WAKE_NEXT 4'h2
`endif

// ==== design/shs_standby_ctrl.v ====
// Purpose: halt/stop standby controller between cpu core and interrupt logic
// Assumes: i_clk is the system clock; oscillator state reported by i_osc_running
//          the oscillator cell reports its state asynchronously
// Notes: settle register reached by the cpu data-memory port at its fixed address
//        only the three select bits are stored; the upper bits always read zero
//        halt wake waits use the shorter figure of each pair the core allows
//        codes 5..7 are prohibited and fall back to the longest settle wait
//        after a real stop the settle counter runs only once the restarted oscillator is seen
`timescale 1ns/1ps
`default_nettype none
`include "shs_defs.vh"
module shs_standby_ctrl #(
    parameter CNT_W = 18
) (
    input wire i_clk,
    input wire i_resetn,
    input wire i_halt_exec,
    input wire i_stop_exec,
    input wire i_irq_pending,
    input wire i_ack_enable_flag,
    input wire i_nmi_req,
    input wire i_hold_instr,
    input wire i_instr_done,
    input wire i_osc_running,
    input wire i_wr_en,
    input wire i_rd_en,
    input wire [15:0] i_addr,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata,
    output wire o_cpu_clk_en,
    output wire o_osc_enable,
    output reg o_vector_req,
    output reg o_resume_next,
    output wire o_in_halt,
    output wire o_in_stop,
    output reg o_retain
);
    // sequencer states; settle serves both stop exit and stop degraded to halt
    localparam [2:0] ST_RUN = 3'h0;
    localparam [2:0] ST_HALT = 3'h1;
    localparam [2:0] ST_STOP = 3'h2;
    localparam [2:0] ST_SETTLE = 3'h3;
    localparam [2:0] ST_WAKE = 3'h4;

    // exponent for the selected settle code; unknown codes fall back to longest
    // a shift of one by this exponent gives the settle length in clocks
    function [4:0] settle_exp;
        input [2:0] sel;
        begin
            case (sel)
                `SHS_SEL_W12: settle_exp = `SHS_EXP_W12;
                `SHS_SEL_W14: settle_exp = `SHS_EXP_W14;
                `SHS_SEL_W15: settle_exp = `SHS_EXP_W15;
                `SHS_SEL_W16: settle_exp = `SHS_EXP_W16;
                `SHS_SEL_W17: settle_exp = `SHS_EXP_W17;
                default: settle_exp = `SHS_EXP_W17;
            endcase
        end
    endfunction

    // oscillator status comes from the analogue cell, so synchronise it
    // nothing but the second flop is read, so a metastable first stage stays contained
    reg osc_s1_q;
    reg osc_s2_q;
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
        end else begin
            osc_s1_q <= i_osc_running;
            osc_s2_q <= osc_s1_q;
        end
    end

    // settle select register and the mode sequencer state
    reg [7:0] settle_sel_q;
    reg [2:0] state_q;
    reg [2:0] state_d;
    // one down-counter serves both the halt wake wait and the stop settle wait
    reg [CNT_W-1:0] cnt_q;
    reg [CNT_W-1:0] cnt_d;
    // outcome chosen at release: vector or continue with the next instruction
    reg vec_q;
    reg vec_d;
    // last completed instruction was of the interrupt-hold kind
    reg held_q;
    // stop degraded to halt because a request was already pending
    reg stop_halt_q;
    reg stop_halt_d;
    // oscillator seen stopped since stop entry; guards against a stale running flag
    reg osc_down_q;

    // register decode is a plain compare against the fixed data-memory address
    wire sel_hit = (i_addr == `SHS_SETTLE_ADDR);
    wire [CNT_W-1:0] one = {{(CNT_W-1){1'b0}}, 1'b1};
    // settle length follows the register live, so a rewrite during stop counts at restart
    wire [2:0] sel_code = settle_sel_q[`SHS_SEL_MSB:`SHS_SEL_LSB];
    wire [CNT_W-1:0] settle_len = one << settle_exp(sel_code);
    // halt wake waits; the core accepts either figure of each pair, the shorter saves a clock
    wire [CNT_W-1:0] wake_vec_len = {{(CNT_W-4){1'b0}}, `SHS_WAKE_VEC};
    wire [CNT_W-1:0] wake_next_len = {{(CNT_W-4){1'b0}}, `SHS_WAKE_NEXT};
    // priority never gates the pending request; it only shapes acknowledgement
    wire wake_src = i_irq_pending | i_nmi_req;
    // a non-maskable request vectors whatever the acknowledge enable flag says
    wire do_vector = i_nmi_req | i_ack_enable_flag;
    // one-cycle view of the sequencer returning to run, shared by the outcome pulses
    wire release_run = (state_q != ST_RUN) && (state_d == ST_RUN);

    // settle select register: only the low three bits are implemented
    // prohibited codes are stored as written; the length decode treats them as longest
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            settle_sel_q <= `SHS_SETTLE_RESET;
        end else if (i_wr_en && sel_hit) begin
            settle_sel_q <= {5'h00, i_wdata[`SHS_SEL_MSB:`SHS_SEL_LSB]};
        end
    end

    // read data held in a flop; unmapped addresses read zero
    // the flop keeps its value between reads, so the core may sample it late
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
        end else if (i_rd_en) begin
            o_rdata <= sel_hit ? settle_sel_q : 8'h00;
        end
    end

    // hold instruction defers acknowledgement past the next ordinary instruction
    // only the most recently completed instruction matters, so each completion reloads it
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            held_q <= 1'b0;
        end else if (i_instr_done) begin
            held_q <= i_hold_instr;
        end
    end

    // mode sequencer: run, halt, stop, settle and wake
    // settle serves both a real stop exit and a stop that degraded to halt
    // the stop hold while the oscillator is off sits in the state register below
    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        vec_d = vec_q;
        stop_halt_d = stop_halt_q;
        case (state_q)
            ST_RUN: begin
                // only run sees instructions; stop wins over a halt in the same cycle
                if (i_stop_exec) begin
                    if (i_irq_pending) begin
                        // pending request: stop degrades to halt plus settle wait
                        state_d = ST_SETTLE;
                        cnt_d = settle_len;
                        vec_d = do_vector;
                        stop_halt_d = 1'b1;
                    end else begin
                        state_d = ST_STOP;
                    end
                end else if (i_halt_exec) begin
                    state_d = ST_HALT;
                end
            end
            ST_HALT: begin
                if (wake_src) begin
                    state_d = ST_WAKE;
                    vec_d = do_vector;
                    if (do_vector) begin
                        cnt_d = wake_vec_len;
                    end else begin
                        cnt_d = wake_next_len;
                    end
                end
            end
            ST_STOP: begin
                // count nothing until the oscillator really runs again; the down flag
                // keeps the lagging running flag of the entry cycles from starting it early
                if (osc_s2_q && osc_down_q) begin
                    state_d = ST_SETTLE;
                    cnt_d = settle_len;
                end
                vec_d = do_vector;
            end
            ST_SETTLE: begin
                // cpu stays gated until the full settle count has run out
                if (cnt_q == one) begin
                    state_d = ST_RUN;
                    stop_halt_d = 1'b0;
                end
                cnt_d = cnt_q - one;
            end
            ST_WAKE: begin
                // short wake after halt; the oscillator never stopped
                if (cnt_q == one) begin
                    state_d = ST_RUN;
                end
                cnt_d = cnt_q - one;
            end
            default: state_d = ST_RUN;
        endcase
    end

    // the synchronised running flag lags stop entry by a few clocks; a restart only
    // counts once the flag has first been seen low inside this stop
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            osc_down_q <= 1'b0;
        end else if (state_q != ST_STOP) begin
            osc_down_q <= 1'b0;
        end else if (!osc_s2_q) begin
            osc_down_q <= 1'b1;
        end
    end

    // stop mode waits for an unmasked request before asking the oscillator back
    // a non-maskable request does not release stop, so only the pending flag is used
    reg osc_req_q;
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            osc_req_q <= 1'b1;
        end else if (state_q == ST_RUN && i_stop_exec && !i_irq_pending) begin
            osc_req_q <= 1'b0;
        end else if (state_q == ST_STOP && i_irq_pending) begin
            osc_req_q <= 1'b1;
        end
    end

    // async reset also releases halt and stop, restarting from the reset vector
    // retention of cpu contents is the core's business; only the mode lives here
    // a stop cut by reset leaves the oscillator request raised again at once
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= ST_RUN;
            cnt_q <= {CNT_W{1'b0}};
            vec_q <= 1'b0;
            stop_halt_q <= 1'b0;
        end else begin
            // stop leaves only once oscillator is requested again
            if (state_q == ST_STOP && !osc_req_q) begin
                state_q <= ST_STOP;
            end else begin
                state_q <= state_d;
            end
            cnt_q <= cnt_d;
            vec_q <= vec_d;
            stop_halt_q <= stop_halt_d;
        end
    end

    // outcome pulse on the return to run; held request defers vectoring
    // pulses, not levels: the core takes them in the single cycle it resumes
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_vector_req <= 1'b0;
            o_resume_next <= 1'b0;
        end else begin
            o_vector_req <= release_run && vec_q && !held_q;
            o_resume_next <= release_run && (!vec_q || held_q);
        end
    end

    // retention flag freezes port latches and cpu state outside run
    // taken from the next state so it rises together with the clock gate
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_retain <= 1'b0;
        end else begin
            o_retain <= (state_d != ST_RUN);
        end
    end

    // cpu clock gated in every non-run state; oscillator off only in true stop
    assign o_cpu_clk_en = (state_q == ST_RUN);
    // the oscillator request is a flop, so the enable pin never glitches
    assign o_osc_enable = osc_req_q;
    // stop that degraded to halt reports halt while it settles
    assign o_in_halt = (state_q == ST_HALT) || stop_halt_q;
    // the settle phase after a real stop reports neither mode
    assign o_in_stop = (state_q == ST_STOP);
endmodule
`default_nettype wire

// ==== verification/shs_osc_model.sv ====
// Purpose: oscillator stand-in on the far side of the standby controller
// Assumes: shares the bench clock; only its running flag is modelled
// Notes: restart takes START plus one clocks, so early settle counting shows up
`timescale 1ns/1ps
`default_nettype none
module shs_osc_model #(
    parameter int START = 6
) (
    input wire logic i_clk,
    input wire logic i_osc_enable,
    output logic o_osc_running
);
    int cnt = START;
    initial o_osc_running = 1'b1;
    // the oscillator dies at once but builds up slowly after enable
    always @(posedge i_clk) begin
        if (!i_osc_enable) begin
            cnt <= 0;
            o_osc_running <= 1'b0;
        end else if (cnt < START) begin
            cnt <= cnt + 1;
        end else begin
            o_osc_running <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== verification/shs_standby_monitor.sv ====
// Purpose: port assertions for the standby controller
// Assumes: bound to shs_standby_ctrl, one clock domain
// Notes: wake windows allow the spare clock the rules permit
`timescale 1ns/1ps
`default_nettype none
`include "shs_defs.vh"
module shs_standby_monitor (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_halt_exec,
    input wire logic i_stop_exec,
    input wire logic i_irq_pending,
    input wire logic i_ack_enable_flag,
    input wire logic i_nmi_req,
    input wire logic i_rd_en,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] o_rdata,
    input wire logic o_cpu_clk_en,
    input wire logic o_osc_enable,
    input wire logic o_vector_req,
    input wire logic o_resume_next,
    input wire logic o_in_halt,
    input wire logic o_in_stop,
    input wire logic o_retain
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    // entry and release relations; nmi and irq wakes are timed from the rising request
    a_halt_entry: assert property (i_halt_exec && !i_stop_exec && o_cpu_clk_en |=> !o_cpu_clk_en && o_in_halt) else $error("halt entry");
    a_stop_entry: assert property (i_stop_exec && o_cpu_clk_en && !i_irq_pending |=> o_in_stop && !o_osc_enable) else $error("stop entry");
    a_stop_drop: assert property (i_stop_exec && o_cpu_clk_en && i_irq_pending |=> o_in_halt && !o_in_stop) else $error("stop drop");
    a_halt_osc: assert property (o_in_halt |-> o_osc_enable) else $error("osc off in halt");
    a_retain_set: assert property ($fell(o_cpu_clk_en) |-> ##[0:1] o_retain) else $error("retain late");
    a_nmi_wake: assert property ($rose(i_nmi_req) && o_in_halt |-> ##[8:11] o_vector_req) else $error("nmi wake");
    a_irq_next: assert property ($rose(i_irq_pending) && o_in_halt && !i_ack_enable_flag && !i_nmi_req
        |-> ##[2:5] o_resume_next) else $error("irq wake");
    a_stop_wake: assert property (o_in_stop && i_irq_pending |-> ##[1:2] o_osc_enable) else $error("stop wake");
    a_rd_other: assert property (i_rd_en && i_addr != `SHS_SETTLE_ADDR |=> o_rdata == 8'h00) else $error("rd other");
    a_rd_upper: assert property (i_rd_en |=> o_rdata[7:3] == 5'h00) else $error("rd upper");
    c_vec: cover property (o_vector_req);
    c_next: cover property (o_resume_next);
    c_stop: cover property (o_in_stop ##1 o_osc_enable);
endmodule
bind shs_standby_ctrl shs_standby_monitor shs_standby_monitor_i (.*);
`default_nettype wire

// ==== verification/testbench.sv ====
// Purpose: self-checking bench for the standby controller
// Assumes: oscillator model restarts seven clocks after enable
// Notes: settle waits use code 0 so the run stays short
`timescale 1ns/1ps
`default_nettype none
`include "shs_defs.vh"
module testbench;
    logic i_clk = 0, i_resetn = 0, i_halt_exec = 0, i_stop_exec = 0, i_irq_pending = 0, rd_seen = 0;
    logic i_ack_enable_flag = 0, i_nmi_req = 0, i_wr_en = 0, i_rd_en = 0, i_osc_running;
    logic i_hold_instr = 0, i_instr_done = 0;
    logic o_cpu_clk_en, o_osc_enable, o_vector_req, o_resume_next, o_in_halt, o_in_stop, o_retain;
    logic [15:0] i_addr = 0;
    logic [7:0] i_wdata = 0, o_rdata, rd_exp[$];
    logic [31:0] v;
    logic q_kind[$];
    int q_lo[$], q_hi[$], cyc = 0, n_fail = 0, checks = 0, seed = 31355;
    always #2 i_clk = ~i_clk;
    shs_standby_ctrl shs_standby_ctrl_i (.*);
    shs_osc_model shs_osc_model_i (.i_clk(i_clk), .i_osc_enable(o_osc_enable), .o_osc_running(i_osc_running));
    task automatic tick;
        @(negedge i_clk);
    endtask
    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t read %h not %h", $time, got, exp);
        end
    endtask
    task automatic cmp_state(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        i_addr = a;
        i_wdata = d;
        i_wr_en = 1;
        tick;
        i_wr_en = 0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        rd_exp.push_back(e);
        i_addr = a;
        i_rd_en = 1;
        tick;
        i_rd_en = 0;
    endtask
    // note the wake kind and the cycle window in which its pulse must show
    task automatic expect_wake(input logic k, input int lo, input int span);
        q_kind.push_back(k);
        q_lo.push_back(cyc + lo);
        q_hi.push_back(cyc + lo + span);
    endtask
    // a completed instruction of the hold kind (or not) precedes each halt
    task automatic halt_wake(input logic nmi, input logic ack, input logic hold);
        i_hold_instr = hold;
        i_instr_done = 1;
        tick;
        i_instr_done = 0;
        i_ack_enable_flag = ack;
        i_halt_exec = 1;
        tick;
        i_halt_exec = 0;
        cmp_state(o_cpu_clk_en | !o_osc_enable, 1'b0, "halt gating");
        repeat (3) tick;
        expect_wake((nmi | ack) & !hold, (nmi | ack) ? 9 : 3, 2);
        i_nmi_req = nmi;
        i_irq_pending = !nmi;
        repeat (14) tick;
        i_nmi_req = 0;
        i_irq_pending = 0;
        tick;
    endtask
    // the early window catches a settle count started before the oscillator runs
    task automatic stop_wake(input logic pre);
        i_ack_enable_flag = !pre;
        i_irq_pending = pre;
        expect_wake(!pre, pre ? 4097 : 4123, 16);
        i_stop_exec = 1;
        tick;
        i_stop_exec = 0;
        cmp_state(o_in_stop, !pre, "stop entry");
        cmp_state(o_in_halt, pre, "stop drop");
        repeat (20) tick;
        i_irq_pending = 1;
        repeat (4150) tick;
        i_irq_pending = 0;
        tick;
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // a hang ends the run as a mismatch
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        rd_seen <= i_rd_en;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish;
        end
    end
    // results are judged half a cycle after the edge that made them
    always @(negedge i_clk) begin
        if (rd_seen) cmp_reg(o_rdata, rd_exp.pop_front());
        if (o_vector_req | o_resume_next) begin
            cmp_state(o_vector_req, q_kind.pop_front(), "wake kind");
            cmp_state(cyc >= q_lo[0] && cyc <= q_hi[0], 1'b1, "wake time");
            void'(q_lo.pop_front());
            void'(q_hi.pop_front());
        end
    end
    initial begin
        repeat (4) tick;
        i_resetn = 1;
        rd(`SHS_SETTLE_ADDR, `SHS_SETTLE_RESET);
        for (int c = 0; c < 5; c++) begin
            v = $random(seed);
            wr(`SHS_SETTLE_ADDR, {v[4:0], c[2:0]});
            rd(`SHS_SETTLE_ADDR, {5'h00, c[2:0]});
        end
        wr(16'hfffb, 8'hff);
        rd(16'hfff9, 8'h00);
        wr(`SHS_SETTLE_ADDR, {5'h00, `SHS_SEL_W12});
        halt_wake(0, 0, 0);
        halt_wake(0, 1, 1);
        halt_wake(0, 1, 0);
        halt_wake(1, 0, 0);
        stop_wake(0);
        stop_wake(1);
        rd(`SHS_SETTLE_ADDR, {5'h00, `SHS_SEL_W12});
        i_halt_exec = 1;
        tick;
        i_halt_exec = 0;
        i_resetn = 0;
        tick;
        cmp_state(o_cpu_clk_en & !o_in_halt, 1'b1, "reset release");
        i_resetn = 1;
        rd(`SHS_SETTLE_ADDR, `SHS_SETTLE_RESET);
        tick;
        cmp_state(q_kind.size() == 0, 1'b1, "missing wake");
        tally_and_finish;
    end
endmodule
`default_nettype wire
